// ### tap_decode_map.vh
// Instruction codes, register sizes and capture patterns for the test port decoder.
`ifndef TAP_DECODE_MAP_VH
`define TAP_DECODE_MAP_VH
`define IR_WIDTH          3
`define INSN_EXTEST       3'h0
`define INSN_IDCODE       3'h1
`define INSN_SAMPLE_Z     3'h2
`define INSN_RESERVED_A   3'h3
`define INSN_SAMPLE_PRE   3'h4
`define INSN_VENDOR       3'h5
`define INSN_RESERVED_B   3'h6
`define INSN_BYPASS       3'h7
`define IR_CAPTURE_LOW    2'h1
`define IR_CAPTURE_HIGH   1'h0
`define ID_WIDTH          32
`define ID_CODE_DEFAULT   32'h0000_0001
`define SEL_BSR           2'h0
`define SEL_ID            2'h1
`define SEL_BYPASS        2'h2
`define TAP_RESET         4'hF
`define TAP_IDLE          4'hC
`define TAP_SEL_DR        4'h7
`define TAP_CAP_DR        4'h6
`define TAP_SHIFT_DR      4'h2
`define TAP_EXIT1_DR      4'h1
`define TAP_PAUSE_DR      4'h3
`define TAP_EXIT2_DR      4'h0
`define TAP_UPD_DR        4'h5
`define TAP_SEL_IR        4'h4
`define TAP_CAP_IR        4'hE
`define TAP_SHIFT_IR      4'hA
`define TAP_EXIT1_IR      4'h9
`define TAP_PAUSE_IR      4'hB
`define TAP_EXIT2_IR      4'h8
`define TAP_UPD_IR        4'hD
`endif

// ### tap_state_machine.v
// Test access port state sequencer stepped on each rising link-clock edge.
`timescale 1ns/1ps
`include "tap_decode_map.vh"
module tap_state_machine (
   input  wire       clk,
   input  wire       rst_n,
   input  wire       tck_rise,
   input  wire       tms,
   output reg  [3:0] state_reg
);
   reg [3:0] state_next;

   always @* begin
      state_next = state_reg;
      if (tck_rise) begin
         case (state_reg)
            `TAP_RESET:    state_next = tms ? `TAP_RESET    : `TAP_IDLE;
            `TAP_IDLE:     state_next = tms ? `TAP_SEL_DR   : `TAP_IDLE;
            `TAP_SEL_DR:   state_next = tms ? `TAP_SEL_IR   : `TAP_CAP_DR;
            `TAP_CAP_DR:   state_next = tms ? `TAP_EXIT1_DR : `TAP_SHIFT_DR;
            `TAP_SHIFT_DR: state_next = tms ? `TAP_EXIT1_DR : `TAP_SHIFT_DR;
            `TAP_EXIT1_DR: state_next = tms ? `TAP_UPD_DR   : `TAP_PAUSE_DR;
            `TAP_PAUSE_DR: state_next = tms ? `TAP_EXIT2_DR : `TAP_PAUSE_DR;
            `TAP_EXIT2_DR: state_next = tms ? `TAP_UPD_DR   : `TAP_SHIFT_DR;
            `TAP_UPD_DR:   state_next = tms ? `TAP_SEL_DR   : `TAP_IDLE;
            `TAP_SEL_IR:   state_next = tms ? `TAP_RESET    : `TAP_CAP_IR;
            `TAP_CAP_IR:   state_next = tms ? `TAP_EXIT1_IR : `TAP_SHIFT_IR;
            `TAP_SHIFT_IR: state_next = tms ? `TAP_EXIT1_IR : `TAP_SHIFT_IR;
            `TAP_EXIT1_IR: state_next = tms ? `TAP_UPD_IR   : `TAP_PAUSE_IR;
            `TAP_PAUSE_IR: state_next = tms ? `TAP_EXIT2_IR : `TAP_PAUSE_IR;
            `TAP_EXIT2_IR: state_next = tms ? `TAP_UPD_IR   : `TAP_SHIFT_IR;
            `TAP_UPD_IR:   state_next = tms ? `TAP_SEL_DR   : `TAP_IDLE;
            default:       state_next = `TAP_RESET;
         endcase
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= `TAP_RESET;
      end else begin
         state_reg <= state_next;
      end
   end
endmodule // tap_state_machine

// ### jtag_instruction_decode.v
// Instruction register, decode and serial data path of the memory's test access port.
// How it works
// - Code 000 routes the boundary scan chain between the serial input and output.
// - Code 001 loads the fixed identification word at capture and shifts it out.
// - Code 010 samples the pins into the boundary chain, shifts it and floats all memory outputs.
// - Reserved codes 011 and 110 behave exactly like bypass.
// - Code 100 samples the pins into the boundary chain and shifts it, outputs left alone.
// - Code 111 places the one-bit bypass stage in the serial path.
// - Identification is the active instruction after reset and in the test-logic-reset state.
// - Codes are binary, most significant bit on the left, shifted in least significant first.
// - The instruction register is three bits and instructions are three bits long.
// - Capture of the instruction register loads 01 into its two low bits.
// - A shifted instruction becomes active only at the update step.
// - Bypass is a single flip-flop giving one stage of delay.
`timescale 1ns/1ps
`include "tap_decode_map.vh"
module jtag_instruction_decode #(
   parameter          BSR_WIDTH = 8,
   parameter [31:0]   ID_CODE   = `ID_CODE_DEFAULT
) (
   input  wire                 ref_clk,
   input  wire                 rst_n,
   input  wire                 tck,
   input  wire                 tms,
   input  wire                 tdi,
   output reg                  tdo,
   output reg                  tdo_oe,
   input  wire [BSR_WIDTH-1:0] io_ring,
   output reg  [BSR_WIDTH-1:0] bsr_update,
   output reg                  extest_drive,
   output reg                  outputs_hiz,
   output reg  [2:0]           active_insn
);
   // ID_CODE is arbitrary; replace with the product's own code.
   reg [1:0] rst_sync_reg;
   wire      rst_core_n = rst_sync_reg[1];
   reg [2:0] tck_sync_reg;
   reg [1:0] tms_sync_reg;
   reg [1:0] tdi_sync_reg;
   reg [BSR_WIDTH-1:0] ring_sync1_reg;
   reg [BSR_WIDTH-1:0] ring_sync2_reg;
   wire [3:0] state;
   reg [`IR_WIDTH-1:0] ir_shift_reg;
   reg [`ID_WIDTH-1:0] id_shift_reg;
   reg [BSR_WIDTH-1:0] bsr_shift_reg;
   reg                 bypass_reg;

   // Link-clock edges are seen about three reference cycles after the pin moves.
   // The low phase lasts at least four reference cycles, so the serial output settles in time.
   wire tck_rise = tck_sync_reg[1] & ~tck_sync_reg[2];
   wire tck_fall = ~tck_sync_reg[1] & tck_sync_reg[2];
   wire tms_s    = tms_sync_reg[1];
   wire tdi_s    = tdi_sync_reg[1];

   // Codes without a scan register of their own fall back to the bypass stage.
   function [1:0] data_select;
      input [2:0] code;
      begin
         case (code)
            `INSN_EXTEST:     data_select = `SEL_BSR;
            `INSN_IDCODE:     data_select = `SEL_ID;
            `INSN_SAMPLE_Z:   data_select = `SEL_BSR;
            `INSN_SAMPLE_PRE: data_select = `SEL_BSR;
            `INSN_RESERVED_A: data_select = `SEL_BYPASS;
            `INSN_RESERVED_B: data_select = `SEL_BYPASS;
            `INSN_VENDOR:     data_select = `SEL_BYPASS;
            `INSN_BYPASS:     data_select = `SEL_BYPASS;
            default:          data_select = `SEL_BYPASS;
         endcase
      end
   endfunction

   wire [1:0] sel = data_select(active_insn);

   // Reset takes effect at once but leaves through two flops so every register wakes together.
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end

   // Link pins cross into the reference clock through two flops before use.
   always @(posedge ref_clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         tck_sync_reg <= 3'h0;
         tms_sync_reg <= 2'h3;
         tdi_sync_reg <= 2'h0;
      end else begin
         tck_sync_reg <= {tck_sync_reg[1:0], tck};
         tms_sync_reg <= {tms_sync_reg[0], tms};
         tdi_sync_reg <= {tdi_sync_reg[0], tdi};
      end
   end

   // The pin ring also passes two flops; the memory clock is unrelated to the link clock.
   always @(posedge ref_clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         ring_sync1_reg <= {BSR_WIDTH{1'b0}};
         ring_sync2_reg <= {BSR_WIDTH{1'b0}};
      end else begin
         ring_sync1_reg <= io_ring;
         ring_sync2_reg <= ring_sync1_reg;
      end
   end

   // The sequencer steps once per detected rising edge of the link clock.
   tap_state_machine u_tap (
      .clk       (ref_clk),
      .rst_n     (rst_core_n),
      .tck_rise  (tck_rise),
      .tms       (tms_s),
      .state_reg (state)
   );

   // Serial registers act on rising link-clock edges.
   always @(posedge ref_clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         ir_shift_reg <= {`IR_WIDTH{1'b0}};
      end else if (tck_rise) begin
         if (state == `TAP_CAP_IR) begin
            ir_shift_reg <= {`IR_CAPTURE_HIGH, `IR_CAPTURE_LOW};
         end else if (state == `TAP_SHIFT_IR) begin
            ir_shift_reg <= {tdi_s, ir_shift_reg[`IR_WIDTH-1:1]};
         end
      end
   end

   always @(posedge ref_clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         id_shift_reg <= {`ID_WIDTH{1'b0}};
      end else if (tck_rise && sel == `SEL_ID) begin
         if (state == `TAP_CAP_DR) begin
            id_shift_reg <= ID_CODE;
         end else if (state == `TAP_SHIFT_DR) begin
            id_shift_reg <= {tdi_s, id_shift_reg[`ID_WIDTH-1:1]};
         end
      end
   end

   always @(posedge ref_clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         bsr_shift_reg <= {BSR_WIDTH{1'b0}};
      end else if (tck_rise && sel == `SEL_BSR) begin
         if (state == `TAP_CAP_DR) begin
            bsr_shift_reg <= ring_sync2_reg;
         end else if (state == `TAP_SHIFT_DR) begin
            bsr_shift_reg <= {tdi_s, bsr_shift_reg[BSR_WIDTH-1:1]};
         end
      end
   end

   always @(posedge ref_clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         bypass_reg <= 1'b0;
      end else if (tck_rise) begin
         if (state == `TAP_CAP_DR) begin
            bypass_reg <= 1'b0;
         end else if (state == `TAP_SHIFT_DR && sel == `SEL_BYPASS) begin
            bypass_reg <= tdi_s;
         end
      end
   end

   // Test-logic-reset wins over an update, which waits for a falling link-clock edge.
   always @(posedge ref_clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         active_insn <= `INSN_IDCODE;
      end else if (state == `TAP_RESET) begin
         active_insn <= `INSN_IDCODE;
      end else if (tck_fall && state == `TAP_UPD_IR) begin
         active_insn <= ir_shift_reg;
      end
   end

   always @(posedge ref_clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         bsr_update <= {BSR_WIDTH{1'b0}};
      end else if (tck_fall && state == `TAP_UPD_DR && sel == `SEL_BSR) begin
         bsr_update <= bsr_shift_reg;
      end
   end

   always @(posedge ref_clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         extest_drive <= 1'b0;
      end else begin
         extest_drive <= (active_insn == `INSN_EXTEST);
      end
   end

   always @(posedge ref_clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         outputs_hiz <= 1'b0;
      end else begin
         outputs_hiz <= (active_insn == `INSN_SAMPLE_Z);
      end
   end

   always @(posedge ref_clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         tdo_oe <= 1'b0;
      end else if (tck_fall) begin
         tdo_oe <= (state == `TAP_SHIFT_IR) || (state == `TAP_SHIFT_DR);
      end
   end

   // The serial output changes only on falling link-clock edges.
   always @(posedge ref_clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         tdo <= 1'b0;
      end else if (tck_fall) begin
         if (state == `TAP_SHIFT_IR) begin
            tdo <= ir_shift_reg[0];
         end else begin
            case (sel)
               `SEL_ID:  tdo <= id_shift_reg[0];
               `SEL_BSR: tdo <= bsr_shift_reg[0];
               default:  tdo <= bypass_reg;
            endcase
         end
      end
   end
endmodule // jtag_instruction_decode

// ### jtag_decode_properties.sv
// Checker of the decode outputs against the link clock and the active instruction.
`timescale 1ns/1ps
module jtag_decode_checker (
   input wire       ref_clk,
   input wire       rst_n,
   input wire       tck,
   input wire       tdo,
   input wire       tdo_oe,
   input wire       extest_drive,
   input wire       outputs_hiz,
   input wire [2:0] active_insn
);
   reg [3:0] gap_reg;
   reg       tck_reg;
   // Counts ref_clk cycles since the link clock last changed level.
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         gap_reg <= 4'hF;
         tck_reg <= 1'b0;
      end else begin
         tck_reg <= tck;
         if (tck != tck_reg) gap_reg <= 4'h0;
         else if (gap_reg != 4'hF) gap_reg <= gap_reg + 4'h1;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   property p_hiz; 1 |=> outputs_hiz == ($past(active_insn) == 3'h2); endproperty
   a_hiz: assert property (p_hiz) else $error("float flag off its code");
   property p_ext; 1 |=> extest_drive == ($past(active_insn) == 3'h0); endproperty
   a_ext: assert property (p_ext) else $error("drive flag off its code");
   property p_excl; !(outputs_hiz && extest_drive); endproperty
   a_excl: assert property (p_excl) else $error("float and drive together");
   property p_byp; active_insn inside {3'h3, 3'h5, 3'h6, 3'h7} |=> !outputs_hiz && !extest_drive;
   endproperty
   a_byp: assert property (p_byp) else $error("bypass code moved outputs");
   property p_insn; $changed(active_insn) |-> gap_reg <= 4'h7; endproperty
   a_insn: assert property (p_insn) else $error("instruction changed off edge");
   property p_tdo; $changed(tdo) |-> !tck && gap_reg <= 4'h7; endproperty
   a_tdo: assert property (p_tdo) else $error("serial out moved off fall");
   property p_oe; $changed(tdo_oe) |-> gap_reg <= 4'h7; endproperty
   a_oe: assert property (p_oe) else $error("enable moved off edge");
   property p_rst; $rose(rst_n) |-> active_insn == 3'h1; endproperty
   a_rst: assert property (p_rst) else $error("no identify after reset");
endmodule // jtag_decode_checker
bind jtag_instruction_decode jtag_decode_checker u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
   .tck(tck), .tdo(tdo), .tdo_oe(tdo_oe), .extest_drive(extest_drive),
   .outputs_hiz(outputs_hiz), .active_insn(active_insn));

// ### scan_master.sv
// Scan master model that steps the test port over an 85 ns link clock.
`timescale 1ns/1ps
module scan_master (
   input  wire ref_clk,
   input  wire tdo,
   output reg  tck,
   output reg  tms,
   output reg  tdi
);
   reg x;
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   // The clock stands low between calls and the data line flips once released.
   task step(input m, input d, output o);
      begin
         @(negedge ref_clk);
         tms = m;
         tdi = d;
         repeat (8) @(negedge ref_clk);
         o = tdo;
         tck = 1'b1;
         repeat (8) @(negedge ref_clk);
         tck = 1'b0;
         tdi = ~d;
      end
   endtask
   // Shifts a code in least significant bit first and stops in Exit1-IR.
   task ir_shift(input [2:0] code, output [2:0] cap);
      integer i;
      begin
         step(1'b1, 1'b0, x);
         step(1'b1, 1'b0, x);
         step(1'b0, 1'b0, x);
         step(1'b0, 1'b0, x);
         for (i = 0; i < 3; i = i + 1) step(i == 2, code[i], cap[i]);
      end
   endtask
   task finish;
      begin
         step(1'b1, 1'b0, x);
         step(1'b0, 1'b0, x);
      end
   endtask
endmodule // scan_master

// ### tb.sv
// Self-checking bench for the test port instruction decode.
`timescale 1ns/1ps
`include "tap_decode_map.vh"
module tb;
   reg         ref_clk = 1'b0;
   reg         rst_n = 1'b0;
   reg  [7:0]  io_ring = 8'h00;
   reg  [31:0] idw = `ID_CODE_DEFAULT;
   wire        tck, tms, tdi, tdo, tdo_oe, extest_drive, outputs_hiz;
   wire [7:0]  bsr_update;
   wire [2:0]  active_insn;
   integer     bad_count = 0, n_tests = 0, seed = 83, i, c;
   reg         x, d;
   reg  [2:0]  cap, prev;
   reg  [7:0]  upd_exp = 8'h00;
   reg         q[$];
   always #2.5 ref_clk = ~ref_clk;
   jtag_instruction_decode #(.BSR_WIDTH(8)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .tck(tck),
      .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .io_ring(io_ring),
      .bsr_update(bsr_update), .extest_drive(extest_drive), .outputs_hiz(outputs_hiz),
      .active_insn(active_insn));
   scan_master sm (.ref_clk(ref_clk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));
   task check(input ok, input string what);
      begin
         n_tests = n_tests + 1;
         if (!ok) begin
            $display("wrong value at %0t: %0s", $time, what);
            bad_count = bad_count + 1;
         end
      end
   endtask
   task close_out;
      begin
         $display("mismatches %0d of %0d compares", bad_count, n_tests);
         if (bad_count == 0 && n_tests > 0) $display("Regression OK");
         else $display("Regression broken");
         $finish;
      end
   endtask
   task do_reset;
      begin
         @(negedge ref_clk) rst_n = 1'b0;
         repeat (16) @(negedge ref_clk);
         rst_n = 1'b1;
         repeat (6) @(negedge ref_clk);
         check(active_insn === 3'h1, "identify after reset");
         sm.step(1'b0, 1'b0, x);
         prev = 3'h1;
      end
   endtask
   initial begin
      #200000;
      bad_count = bad_count + 1;
      close_out;
   end
   initial begin
      do_reset;
      // Reserved codes are loaded on purpose to see them act as bypass.
      for (c = 0; c < 8; c = c + 1) begin
         sm.ir_shift(c, cap);
         check(cap[1:0] === 2'b01, "capture pattern");
         check(active_insn === prev, "early instruction");
         sm.finish;
         repeat (2) @(negedge ref_clk);
         check(active_insn === c, "active code");
         check(outputs_hiz === (c == 2), "float flag");
         check(extest_drive === (c == 0), "drive flag");
         prev = c;
         io_ring = $random(seed);
         q.delete();
         for (i = 0; i < 32; i = i + 1) begin
            if (c == 0 || c == 2 || c == 4) begin
               if (i < 8) q.push_back(io_ring[i]);
            end else if (c == 1) q.push_back(idw[i]);
            else if (i == 0) q.push_back(1'b0);
         end
         sm.step(1'b1, 1'b0, x);
         sm.step(1'b0, 1'b0, x);
         sm.step(1'b0, 1'b0, x);
         repeat (6) @(negedge ref_clk);
         check(tdo_oe === 1'b1, "enable while shifting");
         for (i = 0; i < 40; i = i + 1) begin
            d = $random(seed);
            sm.step(i == 39, d, x);
            check(x === q.pop_front(), "serial path");
            q.push_back(d);
         end
         sm.finish;
         repeat (6) @(negedge ref_clk);
         check(tdo_oe === 1'b0, "enable after shifting");
         if (c == 0 || c == 2 || c == 4) begin
            for (i = 0; i < 8; i = i + 1) upd_exp[i] = q[i];
         end
         check(bsr_update === upd_exp, "parallel update");
         $display("test code %0d done", c);
      end
      for (i = 0; i < 5; i = i + 1) sm.step(1'b1, 1'b0, x);
      repeat (2) @(negedge ref_clk);
      check(active_insn === 3'h1, "identify in test-logic-reset");
      sm.step(1'b0, 1'b0, x);
      $display("test logic reset done");
      do_reset;
      $display("second reset done");
      close_out;
   end
endmodule // tb
